// [dbw_pkg.sv]
// constants and types for the double-data-rate byte write path
package dbw_pkg;
  localparam int ADDR_W = 8;
  localparam int HI_W = ADDR_W - 2;
  localparam int DEPTH = 256;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DATA_W = 36;
  localparam logic [2:0] BEATS = 3'h4;
  localparam logic [2:0] BEAT_ONE = 3'h1;
  localparam logic [3:0] MASK_ALL = 4'hf;
  localparam logic [3:0] MASK_NONE = 4'h0;
  typedef enum logic [1:0] {
    DBW_IDLE = 2'b00,
    DBW_WRITE = 2'b01,
    DBW_READ = 2'b10
  } dbw_state_t;
endpackage

// [dbw_write_path.sv]
// burst sram core with double-data-rate capture and lane write masks
//
// Behaviour
// - both low selects store the whole beat at that edge
// - only lane 0 select low stores low nine bits only
// - only lane 1 select low stores upper nine bits only
// - both selects high leave the location untouched for that beat
// - selects are evaluated afresh at every capture edge of a write burst
// - wide layout adds lanes 2 and 3 for bits 18-26 and 27-35
// - write data captured on rising edges of true and inverse input clock
// - read data launched on output clock edges, input clock edges if both high
// - load and direction sampled only at true input clock rising edge
// - data outputs stay undriven from power-up until a read
// - first beat uses loaded address, later beats internal burst address
// - low two address bits advance linearly, wrapping modulo four
// - every burst is exactly four beats, then a new command is awaited
// - load low starts read or write per direction, high is a no-op
`timescale 1ns/10ps
module dbw_write_path (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic k_in,
  input wire logic k_n_in,
  input wire logic c_in,
  input wire logic c_n_in,
  input wire logic address_load_n_in,
  input wire logic read_not_write_in,
  input wire logic [dbw_pkg::HI_W-1:0] addr_hi_in,
  input wire logic burst_addr_bit0_in,
  input wire logic burst_addr_bit1_in,
  input wire logic lane0_write_mask_n_in,
  input wire logic lane1_write_mask_n_in,
  input wire logic lane2_write_mask_n_in,
  input wire logic lane3_write_mask_n_in,
  input wire logic [dbw_pkg::DATA_W-1:0] dq_in,
  output logic [dbw_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_n_out
);

  // ==========================================================
  // functions
  // lane merge
  function automatic logic [dbw_pkg::DATA_W-1:0] lane_merge(
    input logic [dbw_pkg::DATA_W-1:0] old_w,
    input logic [dbw_pkg::DATA_W-1:0] new_w,
    input logic [dbw_pkg::LANES-1:0] mask_n);
    logic [dbw_pkg::DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < dbw_pkg::LANES; i++) begin
      if (!mask_n[i]) begin
        res[i*dbw_pkg::LANE_W +: dbw_pkg::LANE_W] = new_w[i*dbw_pkg::LANE_W +: dbw_pkg::LANE_W];
      end
    end
    return res;
  endfunction

  function automatic logic [dbw_pkg::ADDR_W-1:0] burst_addr(
    input logic [dbw_pkg::ADDR_W-1:0] base,
    input logic [1:0] beat);
    logic [1:0] low;
    low = base[1:0] + beat;
    return {base[dbw_pkg::ADDR_W-1:2], low};
  endfunction

  // ==========================================================
  // state
  logic [dbw_pkg::DATA_W-1:0] mem [dbw_pkg::DEPTH];
  dbw_pkg::dbw_state_t st_q, st_d;
  logic [2:0] beat_q, beat_d;
  logic [dbw_pkg::ADDR_W-1:0] base_q;
  logic k_q, kn_q, c_q, cn_q;
  logic [dbw_pkg::DATA_W-1:0] dq_q;
  logic oe_n_q;

  // ==========================================================
  // edge and command decode
  wire k_rise = k_in & ~k_q;
  wire kn_rise = k_n_in & ~kn_q;
  wire cap_edge = k_rise | kn_rise;
  wire c_parked = c_in & c_n_in;
  wire c_edge = (c_in & ~c_q) | (c_n_in & ~cn_q);
  wire launch_edge = c_parked ? cap_edge : c_edge;
  wire done = (beat_q == dbw_pkg::BEATS);
  wire idle_or_done = (st_q == dbw_pkg::DBW_IDLE) | done;
  wire cmd_take = k_rise & ~address_load_n_in & idle_or_done;
  wire cmd_write = cmd_take & ~read_not_write_in;
  wire cmd_read = cmd_take & read_not_write_in;
  wire [dbw_pkg::ADDR_W-1:0] load_addr = {addr_hi_in, burst_addr_bit1_in, burst_addr_bit0_in};
  wire [dbw_pkg::LANES-1:0] mask_n = {lane3_write_mask_n_in, lane2_write_mask_n_in,
                                      lane1_write_mask_n_in, lane0_write_mask_n_in};
  wire burst_cap = (st_q == dbw_pkg::DBW_WRITE) & cap_edge & ~done & ~cmd_take;
  wire wr_go = cmd_write | burst_cap;
  wire rd_go = (st_q == dbw_pkg::DBW_READ) & launch_edge & ~done;
  wire [dbw_pkg::ADDR_W-1:0] wr_addr = cmd_write ? load_addr : burst_addr(base_q, beat_q[1:0]);
  wire [dbw_pkg::ADDR_W-1:0] rd_addr = burst_addr(base_q, beat_q[1:0]);
  wire [dbw_pkg::DATA_W-1:0] wr_word = lane_merge(mem[wr_addr], dq_in, mask_n);

  // ==========================================================
  // burst control
  always_comb begin
    st_d = st_q;
    beat_d = beat_q;
    if (k_rise && idle_or_done) begin
      if (cmd_write) begin
        st_d = dbw_pkg::DBW_WRITE;
        beat_d = dbw_pkg::BEAT_ONE;
      end else if (cmd_read) begin
        st_d = dbw_pkg::DBW_READ;
        beat_d = '0;
      end else begin
        st_d = dbw_pkg::DBW_IDLE;
        beat_d = '0;
      end
    end else if (wr_go || rd_go) begin
      beat_d = beat_q + dbw_pkg::BEAT_ONE;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= dbw_pkg::DBW_IDLE;
      beat_q <= '0;
      base_q <= '0;
      k_q <= 1'b0;
      kn_q <= 1'b0;
      c_q <= 1'b0;
      cn_q <= 1'b0;
    end else begin
      st_q <= st_d;
      beat_q <= beat_d;
      k_q <= k_in;
      kn_q <= k_n_in;
      c_q <= c_in;
      cn_q <= c_n_in;
      if (cmd_take) begin
        base_q <= load_addr;
      end
    end
  end

  // ==========================================================
  // array write
  // masks evaluated each beat
  always_ff @(posedge clk_in) begin
    if (wr_go) begin
      mem[wr_addr] <= wr_word;
    end
  end

  // ==========================================================
  // read launch and output enable
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dq_q <= '0;
      oe_n_q <= 1'b1;
    end else if (rd_go) begin
      dq_q <= mem[rd_addr];
      oe_n_q <= 1'b0;
    end else if (launch_edge || st_q != dbw_pkg::DBW_READ) begin
      oe_n_q <= 1'b1;
    end
  end

  assign dq_out = dq_q;
  assign dq_oe_n_out = oe_n_q;

  // ==========================================================
  // checks
  logic chk_v_q;
  logic [dbw_pkg::ADDR_W-1:0] chk_a_q;
  logic [dbw_pkg::ADDR_W-1:0] chk_last_q;
  logic [dbw_pkg::DATA_W-1:0] chk_old_q, chk_new_q;
  logic [dbw_pkg::LANES-1:0] chk_m_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      chk_v_q <= 1'b0;
      chk_a_q <= '0;
      chk_old_q <= '0;
      chk_new_q <= '0;
      chk_m_q <= '0;
      chk_last_q <= '0;
    end else begin
      chk_v_q <= wr_go;
      chk_a_q <= wr_addr;
      chk_old_q <= mem[wr_addr];
      chk_new_q <= dq_in;
      chk_m_q <= mask_n;
      if (wr_go) begin
        chk_last_q <= wr_addr;
      end
    end
  end

  AST_FULL_BEAT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (chk_v_q && chk_m_q == dbw_pkg::MASK_NONE) |-> mem[chk_a_q] == chk_new_q)
    else $error("full beat not stored");
  AST_LANE0_ONLY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (chk_v_q && chk_m_q[1:0] == 2'h2) |->
      mem[chk_a_q][17:0] == {chk_old_q[17:9], chk_new_q[8:0]})
    else $error("lane 0 write wrong");
  AST_LANE1_ONLY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (chk_v_q && chk_m_q[1:0] == 2'h1) |->
      mem[chk_a_q][17:0] == {chk_new_q[17:9], chk_old_q[8:0]})
    else $error("lane 1 write wrong");
  AST_NO_LANES: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (chk_v_q && chk_m_q == dbw_pkg::MASK_ALL) |-> mem[chk_a_q] == chk_old_q)
    else $error("masked beat changed array");
  AST_UPPER_LANES: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (chk_v_q && chk_m_q[3:2] == 2'h1) |->
      mem[chk_a_q][35:18] == {chk_new_q[35:27], chk_old_q[26:18]})
    else $error("upper lanes wrong");
  AST_BEAT_STEP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (burst_cap && !k_rise) |=> beat_q == $past(beat_q) + dbw_pkg::BEAT_ONE)
    else $error("inverse edge did not advance beat");
  AST_LAUNCH_ONLY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!launch_edge && st_q == dbw_pkg::DBW_READ) |=> $stable(dq_out))
    else $error("read data moved off launch edge");
  AST_CMD_AT_K: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!k_rise && st_q == dbw_pkg::DBW_IDLE) |=> st_q == dbw_pkg::DBW_IDLE)
    else $error("command taken off true clock edge");
  AST_QUIET_IDLE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (st_q == dbw_pkg::DBW_IDLE) |=> dq_oe_n_out)
    else $error("outputs driven without read");
  AST_BURST_ADDR: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    burst_cap |-> wr_addr == {chk_last_q[dbw_pkg::ADDR_W-1:2],
                              2'(chk_last_q[1:0] + dbw_pkg::BEAT_ONE)})
    else $error("burst address not linear");
  AST_FOUR_BEATS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    beat_q <= dbw_pkg::BEATS)
    else $error("burst ran past four beats");
  AST_NO_STRAY_WRITE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (st_q == dbw_pkg::DBW_READ && !cmd_take) |-> !wr_go)
    else $error("array written outside write burst");
endmodule

// [dbw_ctl.sv]
// controller model driving the burst sram pins
`timescale 1ns/10ps
module dbw_ctl (
  input wire logic clk_in,
  input wire logic park_in,
  output logic k_out,
  output logic kn_out,
  output logic c_out,
  output logic cn_out,
  output logic load_n_out,
  output logic rnw_out,
  output logic [7:0] a_out,
  output logic [3:0] m_out,
  output logic [35:0] d_out,
  output logic rb_out
);
  logic ev_q = 1'b0;
  initial begin
    {k_out, kn_out, c_out, cn_out, rnw_out, rb_out} = 6'h0;
    {load_n_out, a_out, m_out, d_out} = {1'b1, 48'h0};
  end
  task automatic slot(input logic go, input logic r, input logic [7:0] a,
      input logic [3:0] m, input logic [35:0] d, input logic cap);
    @(posedge clk_in);
    #1;
    {k_out, kn_out} = {~ev_q, ev_q};
    {c_out, cn_out} = {park_in | ~ev_q, park_in | ev_q};
    {load_n_out, rnw_out, a_out, m_out, d_out, rb_out} = {~go, r, a, m, d, 1'b0};
    @(posedge clk_in);
    #1;
    {k_out, kn_out, c_out, cn_out} = {2'b00, park_in, park_in};
    {load_n_out, d_out} = {1'b0, ~d};
    rb_out = cap;
    ev_q = ~ev_q;
  endtask
  task automatic align();
    if (ev_q)
      slot(1'b0, 1'b0, 8'h0, 4'h0, d_out, 1'b0);
  endtask
endmodule

// [testbench.sv]
// self-checking bench for the burst sram write path
`timescale 1ns/10ps
module testbench;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic park = 1'b0;
  logic k, kn, c, cn, load_n, rnw, rb, oe_n;
  logic [7:0] a;
  logic [3:0] m;
  logic [35:0] d, q;
  logic [35:0] mem [256];
  logic [36:0] nq [$];
  logic [36:0] e;
  int err_count = 0;
  int comparisons = 0;
  int seed = 538;
  always #20 clk_in = ~clk_in;
  dbw_ctl dbw_ctl_i (.clk_in(clk_in), .park_in(park), .k_out(k), .kn_out(kn),
    .c_out(c), .cn_out(cn), .load_n_out(load_n), .rnw_out(rnw), .a_out(a), .m_out(m),
    .d_out(d), .rb_out(rb));
  dbw_write_path dbw_write_path_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .k_in(k),
    .k_n_in(kn), .c_in(c), .c_n_in(cn), .address_load_n_in(load_n),
    .read_not_write_in(rnw), .addr_hi_in(a[7:2]), .burst_addr_bit0_in(a[0]),
    .burst_addr_bit1_in(a[1]), .lane0_write_mask_n_in(m[0]),
    .lane1_write_mask_n_in(m[1]), .lane2_write_mask_n_in(m[2]),
    .lane3_write_mask_n_in(m[3]), .dq_in(d), .dq_out(q), .dq_oe_n_out(oe_n));
  task automatic check(input logic [36:0] got, input logic [36:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
      input logic [3:0] mk);
    for (int i = 0; i < 4; i++)
      if (!mk[i])
        o[9*i+:9] = n[9*i+:9];
    return o;
  endfunction
  function automatic logic [7:0] nx(input logic [7:0] b, input int n);
    return {b[7:2], 2'(b[1:0] + n)};
  endfunction
  task automatic wr(input logic [7:0] b, input logic [15:0] mk);
    logic [35:0] v;
    dbw_ctl_i.align();
    for (int n = 0; n < 4; n++) begin
      v = 36'({$random(seed), $random(seed)});
      mem[nx(b, n)] = merge(mem[nx(b, n)], v, mk[4*n+:4]);
      dbw_ctl_i.slot(n == 0, 1'b0, n == 0 ? b : 8'($random(seed)), mk[4*n+:4], v, 1'b0);
    end
  endtask
  task automatic rd(input logic [7:0] b);
    dbw_ctl_i.align();
    dbw_ctl_i.slot(1'b1, 1'b1, b, 4'($random(seed)), d, 1'b0);
    for (int n = 0; n < 5; n++) begin
      nq.push_back(n < 4 ? {1'b0, mem[nx(b, n)]} : {1'b1, 36'h0});
      dbw_ctl_i.slot(1'b0, 1'b1, 8'($random(seed)), 4'($random(seed)), d, 1'b1);
    end
  endtask
  always @(posedge clk_in)
    if (rb === 1'b1 && nq.size() > 0) begin
      e = nq.pop_front();
      if (e[36])
        check({oe_n, 36'h0}, e);
      else
        check({oe_n, q}, e);
    end
  initial begin
    repeat (16) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    check({oe_n, 36'h0}, {1'b1, 36'h0});
    for (int i = 0; i < 4; i++)
      wr(8'h11 + 8'(4 * i), 16'h0);
    wr(8'h16, 16'hfedc);
    for (int i = 0; i < 16; i++) begin
      park = i[0];
      rd(8'h10 | 8'($random(seed) & 15));
      wr(8'h10 | 8'($random(seed) & 15), 16'($random(seed)));
    end
    for (int i = 0; i < 4; i++)
      rd(8'h10 + 8'(4 * i));
    dbw_ctl_i.slot(1'b0, 1'b0, 8'h0, 4'h0, d, 1'b0);
    dbw_ctl_i.slot(1'b1, 1'b1, 8'h10, 4'h0, d, 1'b0);
    dbw_ctl_i.slot(1'b0, 1'b1, 8'h0, 4'h0, d, 1'b0);
    check({oe_n, 36'h0}, {1'b1, 36'h0});
    end_of_test();
  end
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
  task automatic end_of_test();
    if (nq.size() != 0)
      err_count++;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
endmodule
